// *** rtl/emstat_pkg.sv ***
// Package for the MAC statistics counter block: widths, indices, limits.
// Assumes a single MAC clock domain; event inputs are synchronous pulses, except the buffer-full and carrier-sense levels.
package emstat_pkg;
  // ********************************************************************
  // Sizes and limits
  // ********************************************************************
  localparam int EMSTAT_CNT_W = 32;
  localparam int EMSTAT_HIST_N = 15;
  localparam int EMSTAT_COLL_W = 5;
  localparam logic [4:0] EMSTAT_EXCESS_COLL = 5'h10;
  localparam logic [15:0] EMSTAT_LATE_BITS = 16'h0200;
  localparam logic [15:0] EMSTAT_MAX_FRAME = 16'h05ee;
  localparam logic [15:0] EMSTAT_MIN_FRAME = 16'h0040;
  localparam logic [31:0] EMSTAT_CNT_RST = 32'h0000_0000;

  // ********************************************************************
  // Counter indices
  // ********************************************************************
  localparam int EMSTAT_RX_FCS = 0;
  localparam int EMSTAT_RX_ALIGN = 1;
  localparam int EMSTAT_RX_OVERRUN = 2;
  localparam int EMSTAT_RX_COLL_FULL = 3;
  localparam int EMSTAT_RX_MISSED = 4;
  localparam int EMSTAT_RX_SHORT = 5;
  localparam int EMSTAT_RX_BUF_FULL = 6;
  localparam int EMSTAT_RX_INT_ERR = 7;
  localparam int EMSTAT_RX_TOO_LONG = 8;
  localparam int EMSTAT_TX_DEFER = 9;
  localparam int EMSTAT_TX_SINGLE = 10;
  localparam int EMSTAT_TX_MULTI = 11;
  localparam int EMSTAT_TX_TOTAL = 12;
  localparam int EMSTAT_TX_EXCESS = 13;
  localparam int EMSTAT_TX_UNDERRUN = 14;
  localparam int EMSTAT_TX_CARRIER = 15;
  localparam int EMSTAT_TX_HEARTBEAT = 16;
  localparam int EMSTAT_TX_LATE = 17;
  localparam int EMSTAT_TX_INT_ERR = 18;
  localparam int EMSTAT_N_CNT = 19;
  localparam int EMSTAT_IDX_W = 5;

  // Receive frame end report
  typedef struct packed {
    logic done;          // One-cycle pulse at frame end
    logic [15:0] bytes;  // Frame length in bytes
    logic fcs_bad;       // Check sequence mismatch
    logic odd_bits;      // Bit count not a multiple of eight
  } emstat_rx_t;

  // Transmit event report
  typedef struct packed {
    logic ready;         // Pulse: frame ready to send
    logic crs;           // Carrier sense level
    logic coll;          // Pulse: collision on current attempt
    logic [15:0] bits;   // Bits sent in current attempt
    logic ok;            // Pulse: frame sent successfully
    logic underrun;      // Pulse: frame failed on underrun
    logic no_heartbeat;  // Pulse with ok: heartbeat missing
  } emstat_tx_t;
endpackage

// *** rtl/emstat_mem.sv ***
// Histogram memory: one counter word per collision count, registered read.
// Assumes one increment per cycle at most; clear wipes all words in one cycle.
`timescale 1ns/1ps
module emstat_mem #(
  parameter int DEPTH = 15,
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,             // System clock
  input wire logic resetn,              // Async reset, active low
  input wire logic inc,                 // Increment word inc_addr
  input wire logic [3:0] inc_addr,      // Word to increment
  input wire logic clr,                 // Zero every word
  input wire logic [3:0] rd_addr,       // Read address
  output logic [WIDTH-1:0] rd_data      // Registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Read and increment addresses are four bits wide
  if (DEPTH < 1 || DEPTH > 16) begin
    $error("emstat_mem: DEPTH out of range");
  end

  // ********************************************************************
  // Storage
  // ********************************************************************
  // Clear wins over a same-cycle increment; the manager asked for zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (clr) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (inc && 32'(inc_addr) < DEPTH) begin
      mem[inc_addr] <= mem[inc_addr] + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (32'(rd_addr) < DEPTH) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end
endmodule

// *** rtl/emstat_top.sv ***
// Statistics counters for a half-duplex MAC: receive and transmit events.
// Assumes MAC framing logic delivers one-cycle event pulses on clk_sys.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Count each received frame with a bad check sequence.
// RULE2: Count each received frame whose bit count is not a multiple of eight.
// RULE3: Count each buffer overrun losing incoming bytes.
// RULE4: Count receive collisions while the packet buffer is full.
// RULE5: Count packets missed because the buffer was already full.
// RULE6: Count received frames shorter than the legal minimum.
// RULE7: Count each time the packet buffer becomes completely full.
// RULE8: Internal receive error count equals overrun count only.
// RULE9: Count frames deferred because carrier was busy when ready.
// RULE10: Count frames sent after exactly one collision.
// RULE11: Count frames sent after more than one collision.
// RULE12: Total collisions adds every collision of each frame sent successfully.
// RULE13: Abandon after sixteen collisions and count an excess failure.
// RULE14: Count transmit underrun failures.
// RULE15: Count collisions occurring while carrier sense is inactive.
// RULE16: Count missing heartbeat; frame still counts as sent.
// RULE17: Collisions after 512 or more bits sent count as late.
// RULE18: Internal transmit error count equals underrun count only.
// RULE19: Histogram of fifteen counters for frames sent after 1 to 15 collisions.
// RULE20: Clear request zeroes the histogram; otherwise it accumulates.
// RULE21: Count received frames longer than 1518 bytes.
// RULE22: Counters are 32 bits, wrap, and read without stalling counting.
module emstat_top
  import emstat_pkg::*;
#(
  parameter int CNT_W = emstat_pkg::EMSTAT_CNT_W,
  parameter int HIST_N = emstat_pkg::EMSTAT_HIST_N
) (
  input wire logic clk_sys,                    // System clock, 100 MHz
  input wire logic resetn,                     // Async reset, active low
  input wire emstat_pkg::emstat_rx_t rx,       // Receive frame report
  input wire logic rx_overrun,                 // Pulse: buffer overrun
  input wire logic rx_coll,                    // Pulse: collision on receive
  input wire logic rx_arrive,                  // Pulse: new frame arriving
  input wire logic buf_full,                   // Level: packet buffer full
  input wire emstat_pkg::emstat_tx_t tx,       // Transmit event report
  input wire logic [4:0] cnt_sel,              // Counter read select
  output logic [CNT_W-1:0] cnt_data,           // Selected counter value
  input wire logic [3:0] hist_sel,             // Histogram select, 0 = 1 collision
  output logic [CNT_W-1:0] hist_data,          // Selected histogram value
  input wire logic hist_clr,                   // Pulse: zero the histogram
  output logic tx_abort,                       // Pulse: abandon current frame
  output logic [4:0] tx_coll_count             // Collisions on current frame
);
  import emstat_pkg::*;

  if (CNT_W < 1 || CNT_W > 64) begin
    $error("emstat_top: CNT_W out of range");
  end
  if (HIST_N != EMSTAT_HIST_N) begin
    $error("emstat_top: HIST_N must be fifteen");
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input logic [4:0] by);
    bump = v + CNT_W'(by);  // Wraps to zero by truncation
  endfunction

  // ********************************************************************
  // Event decode
  // ********************************************************************
  logic [EMSTAT_N_CNT-1:0] ev;
  logic buf_full_q;
  logic [4:0] coll_cnt;
  logic coll_abort;

  assign coll_abort = tx.coll && (coll_cnt + 5'h01 == EMSTAT_EXCESS_COLL);

  always_comb begin
    ev = '0;
    ev[EMSTAT_RX_FCS] = rx.done && rx.fcs_bad;                          // see RULE1
    ev[EMSTAT_RX_ALIGN] = rx.done && rx.odd_bits;                       // see RULE2
    ev[EMSTAT_RX_OVERRUN] = rx_overrun;                                 // see RULE3
    ev[EMSTAT_RX_COLL_FULL] = rx_coll && buf_full;                      // see RULE4
    ev[EMSTAT_RX_MISSED] = rx_arrive && buf_full;                       // see RULE5
    ev[EMSTAT_RX_SHORT] = rx.done && (rx.bytes < EMSTAT_MIN_FRAME);     // see RULE6
    ev[EMSTAT_RX_BUF_FULL] = buf_full && !buf_full_q;                   // see RULE7
    ev[EMSTAT_RX_INT_ERR] = rx_overrun;                                 // see RULE8
    ev[EMSTAT_RX_TOO_LONG] = rx.done && (rx.bytes > EMSTAT_MAX_FRAME);  // see RULE21
    ev[EMSTAT_TX_DEFER] = tx.ready && tx.crs;                           // see RULE9
    ev[EMSTAT_TX_SINGLE] = tx.ok && coll_cnt == 5'h01;                  // see RULE10
    ev[EMSTAT_TX_MULTI] = tx.ok && coll_cnt > 5'h01;                    // see RULE11
    ev[EMSTAT_TX_TOTAL] = tx.ok && coll_cnt != 5'h00;                   // see RULE12
    ev[EMSTAT_TX_EXCESS] = coll_abort;                                  // see RULE13
    ev[EMSTAT_TX_UNDERRUN] = tx.underrun;                               // see RULE14
    ev[EMSTAT_TX_CARRIER] = tx.coll && !tx.crs;                         // see RULE15
    ev[EMSTAT_TX_HEARTBEAT] = tx.ok && tx.no_heartbeat;                 // see RULE16
    ev[EMSTAT_TX_LATE] = tx.coll && (tx.bits >= EMSTAT_LATE_BITS);      // see RULE17
    ev[EMSTAT_TX_INT_ERR] = tx.underrun;                                // see RULE18
  end

  // Edge of buffer full, so a long full spell counts once
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      buf_full_q <= 1'b0;
    end else begin
      buf_full_q <= buf_full;
    end
  end

  // ********************************************************************
  // Per-frame collision tally
  // ********************************************************************
  // Tally ends with success, underrun or abort; total is added at success
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coll_cnt <= 5'h00;
    end else if (tx.ok || tx.underrun || coll_abort) begin
      coll_cnt <= 5'h00;
    end else if (tx.coll) begin
      coll_cnt <= coll_cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_abort <= 1'b0;
    end else begin
      tx_abort <= coll_abort;  // see RULE13
    end
  end

  assign tx_coll_count = coll_cnt;

  // ********************************************************************
  // Counter bank
  // ********************************************************************
  logic [CNT_W-1:0] cnt [EMSTAT_N_CNT];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < EMSTAT_N_CNT; i++) cnt[i] <= CNT_W'(EMSTAT_CNT_RST);
    end else begin
      for (int i = 0; i < EMSTAT_N_CNT; i++) begin
        if (ev[i]) begin
          if (i == EMSTAT_TX_TOTAL) begin
            cnt[i] <= bump(cnt[i], coll_cnt);  // see RULE12
          end else begin
            cnt[i] <= bump(cnt[i], 5'h01);  // see RULE22
          end
        end
      end
    end
  end

  // Registered read; a read never blocks an update
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_data <= '0;
    end else if (32'(cnt_sel) < EMSTAT_N_CNT) begin
      cnt_data <= cnt[cnt_sel];  // see RULE22
    end else begin
      cnt_data <= '0;
    end
  end

  // ********************************************************************
  // Collision histogram
  // ********************************************************************
  logic hist_inc;
  logic [3:0] hist_addr;

  assign hist_inc = tx.ok && coll_cnt != 5'h00 && coll_cnt < EMSTAT_EXCESS_COLL;  // see RULE19
  assign hist_addr = 4'(coll_cnt - 5'h01);

  emstat_mem #(
    .DEPTH(HIST_N),
    .WIDTH(CNT_W)
  ) u_hist (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inc(hist_inc),
    .inc_addr(hist_addr),
    .clr(hist_clr),  // see RULE20
    .rd_addr(hist_sel),
    .rd_data(hist_data)
  );
endmodule

// *** test/emstat_chk.sv ***
// Checker for the statistics block, bound onto its top module.
// Assumes one clock domain and event pulses sampled on rising edges.
`timescale 1ns/1ps
module emstat_chk
  import emstat_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic clk_sys,               // Clock
  input wire logic resetn,                // Reset, active low
  input wire emstat_pkg::emstat_tx_t tx,  // Transmit events
  input wire logic rx_overrun,            // Overrun pulse
  input wire logic [4:0] cnt_sel,         // Read select
  input wire logic [CNT_W-1:0] cnt_data,  // Read data
  input wire logic tx_abort,              // Abort pulse
  input wire logic [4:0] tx_coll_count    // Collision tally
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence last_coll_s;
    tx.coll && tx_coll_count == 5'h0f;
  endsequence
  sequence frame_end_s;
    tx.ok || tx.underrun;
  endsequence
  // Three quiet cycles cover the one-cycle read latency with margin
  property int_hold_p(int idx, logic ev);
    (cnt_sel == idx && !ev) [*3] |-> $stable(cnt_data);
  endproperty
  abort_after_a: assert property (last_coll_s |=> tx_abort && tx_coll_count == 5'h00)
    else $error("no abort after sixteenth collision");
  abort_cause_a: assert property ($rose(tx_abort) |-> $past(tx.coll) && $past(tx_coll_count) == 5'h0f)
    else $error("abort without sixteenth collision");
  abort_pulse_a: assert property (tx_abort |=> !tx_abort)
    else $error("abort longer than one cycle");
  coll_step_a: assert property (tx.coll && tx_coll_count < 5'h0f |=> tx_coll_count == $past(tx_coll_count) + 5'h01)
    else $error("collision tally did not step");
  frame_clear_a: assert property (frame_end_s |=> tx_coll_count == 5'h00)
    else $error("tally kept after frame end");
  count_hold_a: assert property (!tx.coll && !tx.ok && !tx.underrun |=> $stable(tx_coll_count))
    else $error("tally moved without event");
  count_cap_a: assert property (tx_coll_count <= 5'h0f)
    else $error("tally above fifteen");
  rx_int_a: assert property (int_hold_p(EMSTAT_RX_INT_ERR, rx_overrun))
    else $error("receive internal count moved without overrun");
  tx_int_a: assert property (int_hold_p(EMSTAT_TX_INT_ERR, tx.underrun))
    else $error("transmit internal count moved without underrun");
endmodule
bind emstat_top emstat_chk #(.CNT_W(CNT_W)) u_chk (.clk_sys(clk_sys), .resetn(resetn), .tx(tx),
  .rx_overrun(rx_overrun), .cnt_sel(cnt_sel), .cnt_data(cnt_data), .tx_abort(tx_abort), .tx_coll_count(tx_coll_count));

// *** test/emstat_phy.sv ***
// Transmit-side model of the transceiver and medium.
// Assumes the bench holds go until busy falls, then drops it.
`timescale 1ns/1ps
module emstat_phy
  import emstat_pkg::*;
(
  input wire logic clk_sys,             // Clock
  input wire logic go,                  // Start a frame
  input wire logic [4:0] n,             // Collisions to suffer
  input wire logic [15:0] bits,         // Bits out at each collision
  input wire logic dfr,                 // Medium busy when ready
  input wire logic cse,                 // Carrier lost in collisions
  input wire logic nohb,                // Withhold heartbeat
  input wire logic urun,                // Starve the frame
  output emstat_pkg::emstat_tx_t tx,    // Events to the block
  output logic busy                     // Frame in flight
);
  initial tx = '0;
  initial busy = 0;
  always begin
    wait (go);
    busy = 1;
    @(negedge clk_sys);
    tx.ready = 1;
    tx.crs = dfr;
    @(negedge clk_sys);
    tx.ready = 0;
    tx.crs = !cse;
    repeat (n) begin
      tx.coll = 1;
      tx.bits = bits;
      @(negedge clk_sys);
      tx.coll = 0;
      // Stale count is inverted so a late sample cannot pass by luck
      tx.bits = ~bits;
      // Quiet cycle between collisions so each pulse stands alone
      @(negedge clk_sys);
    end
    if (n != 5'h10) begin
      {tx.ok, tx.underrun, tx.no_heartbeat} = {!urun, urun, nohb};
      @(negedge clk_sys);
      {tx.ok, tx.underrun, tx.no_heartbeat} = 3'h0;
    end
    tx.crs = 0;
    busy = 0;
    wait (!go);
  end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the statistics counter block.
// Assumes the transmit model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb;
  import emstat_pkg::*;
  logic clk_sys = 0, resetn = 0, rx_overrun = 0, rx_coll = 0, rx_arrive = 0, buf_full = 0, hist_clr = 0;
  logic go = 0, dfr = 0, cse = 0, nohb = 0, urun = 0, ab, tx_abort, busy;
  logic [4:0] cnt_sel = '0, n = '0, tx_coll_count;
  logic [3:0] hist_sel = '0;
  logic [15:0] bits = '0;
  logic [31:0] cnt_data, hist_data;
  logic [31:0] ex [20];
  logic [31:0] hx [16];
  emstat_rx_t rx = '0;
  emstat_tx_t tx;
  int n_fail = 0, n_compared = 0, cyc = 0;
  emstat_phy phy (.clk_sys(clk_sys), .go(go), .n(n), .bits(bits), .dfr(dfr), .cse(cse), .nohb(nohb),
    .urun(urun), .tx(tx), .busy(busy));
  emstat_top #(.CNT_W(32), .HIST_N(15)) dut (.clk_sys(clk_sys), .resetn(resetn), .rx(rx), .rx_overrun(rx_overrun),
    .rx_coll(rx_coll), .rx_arrive(rx_arrive), .buf_full(buf_full), .tx(tx), .cnt_sel(cnt_sel), .cnt_data(cnt_data),
    .hist_sel(hist_sel), .hist_data(hist_data), .hist_clr(hist_clr), .tx_abort(tx_abort), .tx_coll_count(tx_coll_count));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end
  task close_out;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] want, input string what);
    n_compared++;
    if (got !== want) begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  // Select held three cycles so the checker sees quiet reads
  task chk_all;
    for (int i = 0; i < 20; i++) begin
      cnt_sel = 5'(i);
      hist_sel = 4'(i);
      repeat (3) @(negedge clk_sys);
      cmp(cnt_data, ex[i], "counter");
      if (i < 16) cmp(hist_data, hx[i], "histogram");
    end
  endtask
  task rxf(input logic [15:0] b, input logic f, input logic o);
    rx = '{done: 1'b1, bytes: b, fcs_bad: f, odd_bits: o};
    ex[EMSTAT_RX_FCS] += 32'(f);
    ex[EMSTAT_RX_ALIGN] += 32'(o);
    ex[EMSTAT_RX_SHORT] += 32'(b < EMSTAT_MIN_FRAME);
    ex[EMSTAT_RX_TOO_LONG] += 32'(b > EMSTAT_MAX_FRAME);
    @(negedge clk_sys);
    rx = '{done: 1'b0, bytes: ~b, fcs_bad: ~f, odd_bits: ~o};
    @(negedge clk_sys);
  endtask
  task frm(input logic [4:0] k, input logic [15:0] b, input logic d, input logic c, input logic h, input logic u);
    {n, bits, dfr, cse, nohb, urun, go, ab} = {k, b, d, c, h, u, 2'b10};
    for (int w = 0; w < 60 && busy !== 1'b0 || w == 0; w++) begin
      @(negedge clk_sys);
      ab |= tx_abort;
    end
    go = 0;
    @(negedge clk_sys);
    cmp(32'(ab), 32'(k == 5'h10), "abort");
    ex[EMSTAT_TX_DEFER] += 32'(d);
    ex[EMSTAT_TX_CARRIER] += c ? 32'(k) : 32'h0;
    ex[EMSTAT_TX_LATE] += (b >= EMSTAT_LATE_BITS) ? 32'(k) : 32'h0;
    if (k == 5'h10) ex[EMSTAT_TX_EXCESS]++;
    else if (u) ex[EMSTAT_TX_UNDERRUN]++;
    else begin
      ex[EMSTAT_TX_HEARTBEAT] += 32'(h);
      ex[EMSTAT_TX_SINGLE] += 32'(k == 5'h01);
      ex[EMSTAT_TX_MULTI] += 32'(k > 5'h01);
      ex[EMSTAT_TX_TOTAL] += 32'(k);
      if (k != 5'h00) hx[k - 5'h01]++;
    end
    ex[EMSTAT_TX_INT_ERR] = ex[EMSTAT_TX_UNDERRUN];
  endtask
  initial begin
    ex = '{default: 32'h0};
    hx = '{default: 32'h0};
    repeat (5) @(negedge clk_sys);
    resetn = 1;
    chk_all;
    rxf(16'h003f, 1'b0, 1'b0);
    rxf(16'h0040, 1'b1, 1'b0);
    rxf(16'h05ee, 1'b0, 1'b1);
    rxf(16'h05ef, 1'b1, 1'b1);
    rx_overrun = 1;
    repeat (2) @(negedge clk_sys);
    {rx_overrun, rx_coll, rx_arrive} = 3'h3;
    // Events before the buffer fills must not count
    @(negedge clk_sys);
    buf_full = 1;
    @(negedge clk_sys);
    {rx_coll, rx_arrive} = 2'h0;
    @(negedge clk_sys);
    buf_full = 0;
    @(negedge clk_sys);
    buf_full = 1;
    @(negedge clk_sys);
    buf_full = 0;
    ex[EMSTAT_RX_OVERRUN] = 32'h2;
    ex[EMSTAT_RX_INT_ERR] = 32'h2;
    ex[EMSTAT_RX_COLL_FULL] = 32'h1;
    ex[EMSTAT_RX_MISSED] = 32'h1;
    ex[EMSTAT_RX_BUF_FULL] = 32'h2;
    chk_all;
    frm(5'h00, 16'h0064, 1'b1, 1'b0, 1'b0, 1'b0);
    frm(5'h01, 16'h0064, 1'b0, 1'b0, 1'b0, 1'b0);
    frm(5'h02, 16'h01ff, 1'b0, 1'b0, 1'b0, 1'b0);
    frm(5'h03, 16'h0200, 1'b0, 1'b1, 1'b1, 1'b0);
    frm(5'h10, 16'h0064, 1'b0, 1'b0, 1'b0, 1'b0);
    frm(5'h02, 16'h0064, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_all;
    for (int k = 1; k < 16; k++) frm(5'(k), 16'h0064, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_all;
    hist_clr = 1;
    @(negedge clk_sys);
    hist_clr = 0;
    // Clear zeroes every word in one cycle; the wait is margin
    repeat (20) @(negedge clk_sys);
    hx = '{default: 32'h0};
    frm(5'h04, 16'h0064, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_all;
    close_out;
  end
endmodule
